// ===== design/rxcf_regs.v
// receive front end configuration registers behind an AXI4-Lite slave
// assumes one 20 MHz clock; analog controls are taken from the outputs
// Notes on behaviour
// - ch select bit: 0 AM, 1 PM
// - ch select picks framing channel when manual and both channels on
// - demod type: 0 peak, 1 mixer
// - lowpass and zero fields passed unchanged
// - low power bit enables low-power receiver
// - LF split: input one AM, two PM
// - LF enable applies LF on input
// - gain loop enable defaults to one
// - gain window: eight pulses or whole receive
// - gain algorithm: preset or reset
// - auto squelch 18.88 us after transmit
// - mixer clock: driver or internal; single internal
// - AM first gain: full, -2.5dB steps, boost
// - PM first gain coded like AM
// - clip bit clips first two stages
// - forced gain: -6 dB, max window
// - later gain codes 0-A, window then cut
// - AM later gain high, PM low
// - later gains load only on reload command
// - defaults at reset and restore command; restore keeps the loaded later gains
// - mask timer 64 carrier steps ends squelch
`include "rxcf_map.vh"
`timescale 1ns/10ps
`default_nettype none
module rxcf_regs (
	// clock and reset
	input wire clk,
	input wire sys_rst,
	// axi4-lite write address and data
	input wire [31:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read
	input wire [31:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// receiver environment
	input wire tx_active,
	input wire rx_channel_am_en,
	input wire rx_channel_pm_en,
	input wire rx_manual_select,
	input wire single_ended_mode,
	// channel and filter controls
	output reg rx_am_enable,
	output reg rx_pm_enable,
	output reg framing_from_pm,
	output reg am_demod_mixer,
	output reg [2:0] lowpass_ctrl,
	output reg [2:0] zero_ctrl,
	// mode controls
	output reg receiver_low_power,
	output reg low_freq_input_split,
	output reg low_freq_input_enable,
	output reg agc_enable,
	output reg agc_full_window,
	output reg agc_reset_alg,
	output reg phase_mixer_clock_source,
	output reg squelch_active,
	// gain controls
	output reg [2:0] am_first_stage_gain,
	output reg [2:0] pm_first_stage_gain,
	output reg stage_clip,
	output reg peer_mode_gain_force,
	output reg [3:0] am_later_stage_gain,
	output reg [3:0] pm_later_stage_gain,
	output reg [3:0] am_digitizer_widen,
	output reg [3:0] pm_digitizer_widen,
	output reg [3:0] am_stage23_cut,
	output reg [3:0] pm_stage23_cut,
	output reg comparator_window_max
);

	// ****************************************
	// constants and helpers
	// ****************************************
	localparam integer SQ_DELAY_CYC = `RXCF_SQ_DELAY_CYC;
	localparam integer MASK_STEP_CYC = `RXCF_MASK_STEP_CYC;
	localparam [1:0] TS_IDLE = 2'b00;
	localparam [1:0] TS_DELAY = 2'b01;
	localparam [1:0] TS_MASK = 2'b10;
	localparam [1:0] RESP_OK = 2'b00;
	localparam [1:0] RESP_SLVERR = 2'b10;

	// map a byte address to a register index, 8'hFF when unaligned
	function [7:0] addr_index;
		input [31:0] a;
		begin
			addr_index = (a[1:0] != 2'b00 || a[31:10] != 22'h0) ?
				8'hFF : a[9:2];
		end
	endfunction
	// digitizer widening part of a later gain code
	function [3:0] win_part;
		input [3:0] c;
		begin
			win_part = (c > `RXCF_LATER_WIN_MAX) ?
				`RXCF_LATER_WIN_MAX : c;
		end
	endfunction
	// stage two and three cut part of a later gain code
	function [3:0] cut_part;
		input [3:0] c;
		reg [3:0] k;
		begin
			k = (c > `RXCF_LATER_MAX) ? `RXCF_LATER_MAX : c;
			cut_part = (k > `RXCF_LATER_WIN_MAX) ?
				k - `RXCF_LATER_WIN_MAX : 4'h0;
		end
	endfunction
	// ****************************************
	// register file
	// ****************************************
	reg [7:0] chan_filt_reg;
	reg [7:0] mode_loop_reg;
	reg [7:0] gain1_reg;
	reg [7:0] gain2_reg;
	reg [7:0] mask_tmr_reg;
	reg [7:0] loaded_gain2_reg;
	reg [1:0] tstate_reg;
	reg [15:0] tcount_reg;
	reg [7:0] step_reg;
	reg tx_prev_reg;
	reg aw_have_reg;
	reg w_have_reg;
	reg [31:0] aw_addr_reg;
	reg [31:0] w_data_reg;
	reg [3:0] w_strb_reg;
	wire [7:0] w_idx;
	wire do_write;
	wire w_byte0;
	wire w_is_cmd;
	wire cmd_default;
	wire cmd_reload;
	wire w_known;
	assign w_idx = addr_index(aw_addr_reg);
	assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
	assign w_byte0 = w_strb_reg[0];
	assign w_is_cmd = do_write && w_byte0 && w_idx == `RXCF_IDX_CMD;
	assign cmd_default = w_is_cmd && w_data_reg[7:0] == `RXCF_CMD_SET_DEFAULT;
	assign cmd_reload = w_is_cmd && w_data_reg[7:0] == `RXCF_CMD_RELOAD_GAIN;
	assign w_known = w_idx == `RXCF_IDX_CHAN_FILT ||
		w_idx == `RXCF_IDX_MODE_LOOP || w_idx == `RXCF_IDX_GAIN1 ||
		w_idx == `RXCF_IDX_GAIN2 || w_idx == `RXCF_IDX_MASK_TMR ||
		w_idx == `RXCF_IDX_CMD;
	// write address and data accepted in either order, one at a time
	always @(posedge clk) begin
		if (sys_rst) begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			aw_addr_reg <= 32'h0000_0000;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OK;
		end else begin
			s_axi_awready <= !aw_have_reg && !s_axi_awready &&
				s_axi_awvalid;
			s_axi_wready <= !w_have_reg && !s_axi_wready && s_axi_wvalid;
			if (s_axi_awready && s_axi_awvalid) begin
				aw_have_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wready && s_axi_wvalid) begin
				w_have_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_have_reg <= 1'b0;
				w_have_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= w_known ? RESP_OK : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	// configuration storage; restore-defaults beats a same-cycle write
	always @(posedge clk) begin
		if (sys_rst || cmd_default) begin
			chan_filt_reg <= `RXCF_RST_CHAN_FILT;
			mode_loop_reg <= `RXCF_RST_MODE_LOOP;
			gain1_reg <= `RXCF_RST_GAIN1;
			gain2_reg <= `RXCF_RST_GAIN2;
			mask_tmr_reg <= `RXCF_RST_MASK_TMR;
		end else if (do_write && w_byte0) begin
			case (w_idx)
				`RXCF_IDX_CHAN_FILT: chan_filt_reg <= w_data_reg[7:0];
				`RXCF_IDX_MODE_LOOP: mode_loop_reg <= w_data_reg[7:0];
				`RXCF_IDX_GAIN1: gain1_reg <= w_data_reg[7:0];
				`RXCF_IDX_GAIN2: gain2_reg <= w_data_reg[7:0];
				`RXCF_IDX_MASK_TMR: mask_tmr_reg <= w_data_reg[7:0];
				default: mask_tmr_reg <= mask_tmr_reg;
			endcase
		end
	end

	// later gains reach the gain loop only on the reload command
	always @(posedge clk) begin
		if (sys_rst) begin
			loaded_gain2_reg <= `RXCF_RST_GAIN2;
		end else if (cmd_reload) begin
			loaded_gain2_reg <= gain2_reg;
		end
	end

	// ****************************************
	// read channel
	// ****************************************
	reg [31:0] rd_word;
	reg rd_ok;
	// decode the read index into data and response
	always @* begin
		rd_word = 32'h0000_0000;
		rd_ok = 1'b1;
		case (addr_index(s_axi_araddr))
			`RXCF_IDX_CHAN_FILT: rd_word = {24'h0, chan_filt_reg};
			`RXCF_IDX_MODE_LOOP: rd_word = {24'h0, mode_loop_reg};
			`RXCF_IDX_GAIN1: rd_word = {24'h0, gain1_reg};
			`RXCF_IDX_GAIN2: rd_word = {24'h0, gain2_reg};
			`RXCF_IDX_MASK_TMR: rd_word = {24'h0, mask_tmr_reg};
			`RXCF_IDX_CMD: rd_word = 32'h0000_0000;
			`RXCF_IDX_STATUS: rd_word = {20'h0, loaded_gain2_reg,
				squelch_active, tx_prev_reg, tstate_reg};
			default: rd_ok = 1'b0;
		endcase
	end

	// one read at a time; address taken and answered the next cycle
	always @(posedge clk) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OK;
		end else begin
			s_axi_arready <= !s_axi_arready && !s_axi_rvalid &&
				s_axi_arvalid;
			if (s_axi_arready && s_axi_arvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_word;
				s_axi_rresp <= rd_ok ? RESP_OK : RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ****************************************
	// automatic squelch timing
	// ****************************************
	// delay after end of transmit, then mask timer in 64-carrier steps;
	// a mask value of four or less ends squelch one cycle after it starts
	always @(posedge clk) begin
		if (sys_rst) begin
			tstate_reg <= TS_IDLE;
			tcount_reg <= 16'h0000;
			step_reg <= 8'h00;
			tx_prev_reg <= 1'b0;
			squelch_active <= 1'b0;
		end else begin
			tx_prev_reg <= tx_active;
			case (tstate_reg)
				TS_IDLE: begin
					squelch_active <= 1'b0;
					if (tx_prev_reg && !tx_active) begin
						tstate_reg <= TS_DELAY;
						tcount_reg <= SQ_DELAY_CYC[15:0] - 16'h0001;
					end
				end
				TS_DELAY: begin
					if (tx_active) begin
						tstate_reg <= TS_IDLE;
					end else if (tcount_reg == 16'h0000) begin
						tstate_reg <= TS_MASK;
						squelch_active <= mode_loop_reg[`RXCF_B_SQ_AUTO];
						tcount_reg <= {8'h00, MASK_STEP_CYC[7:0]};
						step_reg <= 8'h04;
					end else begin
						tcount_reg <= tcount_reg - 16'h0001;
					end
				end
				TS_MASK: begin
					if (tx_active || step_reg >= mask_tmr_reg) begin
						tstate_reg <= TS_IDLE;
						squelch_active <= 1'b0;
					end else if (tcount_reg == 16'h0001) begin
						tcount_reg <= {8'h00, MASK_STEP_CYC[7:0]};
						step_reg <= step_reg + 8'h01;
					end else begin
						tcount_reg <= tcount_reg - 16'h0001;
					end
				end
				default: tstate_reg <= TS_IDLE;
			endcase
		end
	end

	// ****************************************
	// receiver controls
	// ****************************************
	wire ch_pm;
	assign ch_pm = chan_filt_reg[`RXCF_B_RX_CHANNEL_SELECT];
	// controls follow the stored bits one cycle after a write; later gains follow the reload copy
	always @(posedge clk) begin
		if (sys_rst) begin
			rx_am_enable <= 1'b0;
			rx_pm_enable <= 1'b0;
			framing_from_pm <= 1'b0;
			am_demod_mixer <= 1'b0;
			lowpass_ctrl <= 3'h0;
			zero_ctrl <= 3'h0;
			receiver_low_power <= 1'b0;
			low_freq_input_split <= 1'b0;
			low_freq_input_enable <= 1'b0;
			agc_enable <= 1'b0;
			agc_full_window <= 1'b0;
			agc_reset_alg <= 1'b0;
			phase_mixer_clock_source <= 1'b0;
			am_first_stage_gain <= 3'h0;
			pm_first_stage_gain <= 3'h0;
			stage_clip <= 1'b0;
			peer_mode_gain_force <= 1'b0;
			comparator_window_max <= 1'b0;
			am_later_stage_gain <= 4'h0;
			pm_later_stage_gain <= 4'h0;
			am_digitizer_widen <= 4'h0;
			pm_digitizer_widen <= 4'h0;
			am_stage23_cut <= 4'h0;
			pm_stage23_cut <= 4'h0;
		end else begin
			// single channel: select bit picks which one runs
			if (rx_channel_am_en ^ rx_channel_pm_en) begin
				rx_am_enable <= !ch_pm;
				rx_pm_enable <= ch_pm;
			end else begin
				rx_am_enable <= rx_channel_am_en;
				rx_pm_enable <= rx_channel_pm_en;
			end
			if (rx_channel_am_en && rx_channel_pm_en && rx_manual_select) begin
				framing_from_pm <= ch_pm;
			end else begin
				framing_from_pm <= rx_channel_pm_en && !rx_channel_am_en;
			end
			am_demod_mixer <= chan_filt_reg[`RXCF_B_AMD_SEL];
			lowpass_ctrl <= chan_filt_reg[5:3];
			zero_ctrl <= chan_filt_reg[2:0];
			receiver_low_power <= mode_loop_reg[`RXCF_B_LOW_POWER];
			low_freq_input_split <= mode_loop_reg[`RXCF_B_LF_SPLIT];
			low_freq_input_enable <= mode_loop_reg[`RXCF_B_LOW_FREQ_INPUT_ENABLE];
			agc_enable <= mode_loop_reg[`RXCF_B_AGC_EN];
			agc_full_window <= mode_loop_reg[`RXCF_B_AGC_WIN];
			agc_reset_alg <= mode_loop_reg[`RXCF_B_AGC_ALG];
			// single-ended drive has no usable driver phase
			phase_mixer_clock_source <= single_ended_mode ||
				mode_loop_reg[`RXCF_B_PHASE_MIXER_CLOCK_SOURCE];
			am_first_stage_gain <= gain1_reg[7:5];
			pm_first_stage_gain <= gain1_reg[4:2];
			stage_clip <= gain1_reg[`RXCF_B_CLIP];
			peer_mode_gain_force <= gain1_reg[`RXCF_B_GAIN_FORCE];
			am_later_stage_gain <= loaded_gain2_reg[7:4];
			pm_later_stage_gain <= loaded_gain2_reg[3:0];
			// forced gain overrides the loaded codes with -6 dB, max window
			if (gain1_reg[`RXCF_B_GAIN_FORCE]) begin
				comparator_window_max <= 1'b1;
				am_digitizer_widen <= `RXCF_LATER_WIN_MAX;
				pm_digitizer_widen <= `RXCF_LATER_WIN_MAX;
				am_stage23_cut <= 4'h2;
				pm_stage23_cut <= 4'h2;
			end else begin
				comparator_window_max <= 1'b0;
				am_digitizer_widen <= win_part(loaded_gain2_reg[7:4]);
				pm_digitizer_widen <= win_part(loaded_gain2_reg[3:0]);
				am_stage23_cut <= cut_part(loaded_gain2_reg[7:4]);
				pm_stage23_cut <= cut_part(loaded_gain2_reg[3:0]);
			end
		end
	end

endmodule
`default_nettype wire

// ===== design/rxcf_map.vh
// register map, field positions, reset values and timing counts
// assumes a 20 MHz system clock and a 32-bit AXI4-Lite register bus
`ifndef RXCF_MAP_VH
`define RXCF_MAP_VH
// printed offsets are register indices; byte address is four times each
`define RXCF_IDX_CHAN_FILT 8'h0A
`define RXCF_IDX_MODE_LOOP 8'h0B
`define RXCF_IDX_GAIN1 8'h0C
`define RXCF_IDX_GAIN2 8'h0D
`define RXCF_IDX_MASK_TMR 8'h0E
`define RXCF_IDX_CMD 8'h20
`define RXCF_IDX_STATUS 8'h21
// command codes written to the command register
`define RXCF_CMD_SET_DEFAULT 8'h01
`define RXCF_CMD_RELOAD_GAIN 8'h02
// reset values
`define RXCF_RST_CHAN_FILT 8'h00
`define RXCF_RST_MODE_LOOP 8'h1A
`define RXCF_RST_GAIN1 8'hD8
`define RXCF_RST_GAIN2 8'h00
`define RXCF_RST_MASK_TMR 8'h08
// field positions
`define RXCF_B_RX_CHANNEL_SELECT 7
`define RXCF_B_AMD_SEL 6
`define RXCF_B_LOW_POWER 7
`define RXCF_B_LF_SPLIT 6
`define RXCF_B_LOW_FREQ_INPUT_ENABLE 5
`define RXCF_B_AGC_EN 4
`define RXCF_B_AGC_WIN 3
`define RXCF_B_AGC_ALG 2
`define RXCF_B_SQ_AUTO 1
`define RXCF_B_PHASE_MIXER_CLOCK_SOURCE 0
`define RXCF_B_CLIP 1
`define RXCF_B_GAIN_FORCE 0
// gain field limits and steps
`define RXCF_LATER_MAX 4'hA
`define RXCF_LATER_WIN_MAX 4'h4
`define RXCF_STEP_LATER_CDB 8'd30
`define RXCF_STEP_FIRST_CDB 8'd25
`define RXCF_FORCE_CDB 8'd60
// timing: carrier 13.56 MHz, mask step 64 carrier periods, squelch delay
`define RXCF_CLK_HZ 20000000
`define RXCF_FC_HZ 13560000
`define RXCF_MASK_STEP_FC 64
`define RXCF_SQ_DELAY_NS 18880
`define RXCF_SQ_DELAY_CYC ((`RXCF_SQ_DELAY_NS * 20 + 999) / 1000)
`define RXCF_MASK_STEP_CYC ((`RXCF_MASK_STEP_FC * 20000 + 13559) / 13560)
`endif

// ===== tb/rxcf_regs_props.sv
// checker for the receive front end configuration register bank
// assumes it is bound onto rxcf_regs and shares its single clock
`timescale 1ns/10ps
`default_nettype none
module rxcf_regs_props (
	// clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// bus write side
	input wire logic [31:0] s_axi_awaddr,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	// environment
	input wire logic tx_active,
	input wire logic rx_channel_am_en,
	input wire logic rx_channel_pm_en,
	input wire logic rx_manual_select,
	input wire logic single_ended_mode,
	// controls
	input wire logic rx_am_enable,
	input wire logic rx_pm_enable,
	input wire logic framing_from_pm,
	input wire logic agc_enable,
	input wire logic agc_full_window,
	input wire logic phase_mixer_clock_source,
	input wire logic squelch_active,
	input wire logic [2:0] am_first_stage_gain,
	input wire logic [2:0] pm_first_stage_gain,
	input wire logic [3:0] am_later_stage_gain,
	input wire logic [3:0] pm_later_stage_gain,
	input wire logic [3:0] am_digitizer_widen,
	input wire logic [3:0] am_stage23_cut,
	input wire logic comparator_window_max
);
// ******************************
// helpers
// ******************************
logic reload_seen;
logic [2:0] reload_age_reg;
logic [9:0] tx_low_reg;
// reload command seen on the data handshake; address is taken alongside
assign reload_seen = s_axi_wvalid && s_axi_wready &&
	s_axi_awaddr == 32'h80 && s_axi_wdata[7:0] == 8'h02;
// ages saturate so that they never wrap back into a window
always @(posedge clk) begin
	if (sys_rst || reload_seen) begin
		reload_age_reg <= 3'h0;
	end else if (reload_age_reg != 3'h7) begin
		reload_age_reg <= reload_age_reg + 3'h1;
	end
	if (sys_rst || tx_active) begin
		tx_low_reg <= 10'h0;
	end else if (tx_low_reg != 10'h3FF) begin
		tx_low_reg <= tx_low_reg + 10'h1;
	end
end
// ******************************
// properties
// ******************************
default clocking cb @(posedge clk); endclocking
default disable iff (sys_rst);
sequence reload_recent;
	reload_age_reg <= 3'h4;
endsequence
sequence tx_held;
	tx_active [*3];
endsequence
chan_pick_a:
	assert property (!$past(sys_rst) && $past(rx_channel_am_en ^
		rx_channel_pm_en) |-> rx_am_enable ^ rx_pm_enable)
	else $error("single channel not one-hot");
framing_auto_a:
	assert property (!$past(sys_rst) && $past(rx_channel_am_en &&
		rx_channel_pm_en && !rx_manual_select) |-> !framing_from_pm)
	else $error("framing channel wrong in automatic mode");
mixer_single_a:
	assert property (!$past(sys_rst) && $past(single_ended_mode)
		|-> phase_mixer_clock_source)
	else $error("single-ended mode must use internal mixer clock");
force_gain_a:
	assert property (comparator_window_max |->
		am_digitizer_widen == 4'h4 && am_stage23_cut == 4'h2)
	else $error("forced gain not applied");
later_map_a:
	assert property (!comparator_window_max &&
		$stable(comparator_window_max) && $stable(am_later_stage_gain)
		|-> am_digitizer_widen == (am_later_stage_gain > 4'h4 ? 4'h4 :
		am_later_stage_gain) && am_stage23_cut == (am_later_stage_gain <
		4'h5 ? 4'h0 : am_later_stage_gain - 4'h4))
	else $error("later gain code mapped wrongly");
reload_only_a:
	assert property ($changed({am_later_stage_gain, pm_later_stage_gain})
		|-> reload_recent)
	else $error("loaded gain changed without reload");
squelch_start_a:
	assert property ($rose(squelch_active) |->
		tx_low_reg >= 10'd370 && tx_low_reg <= 10'd395)
	else $error("squelch started at wrong time");
squelch_tx_a:
	assert property (tx_held |-> !squelch_active)
	else $error("squelch active while transmitting");
reset_dflt_a:
	assert property ($fell(sys_rst) |=> agc_enable && agc_full_window &&
		am_first_stage_gain == 3'h6 && pm_first_stage_gain == 3'h6)
	else $error("defaults missing after reset");
endmodule
bind rxcf_regs rxcf_regs_props rxcf_regs_props_i (.clk, .sys_rst,
	.s_axi_awaddr, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .tx_active,
	.rx_channel_am_en, .rx_channel_pm_en, .rx_manual_select,
	.single_ended_mode, .rx_am_enable, .rx_pm_enable, .framing_from_pm,
	.agc_enable, .agc_full_window, .phase_mixer_clock_source,
	.squelch_active, .am_first_stage_gain, .pm_first_stage_gain,
	.am_later_stage_gain, .pm_later_stage_gain, .am_digitizer_widen,
	.am_stage23_cut, .comparator_window_max);
`default_nettype wire

// ===== tb/rxcf_regs_tb_top.sv
// self-checking bench for the receive front end configuration registers
// assumes rxcf_regs and its bound checker are compiled before it
`timescale 1ns/10ps
`default_nettype none
module rxcf_regs_tb_top;
// ******************************
// signals
// ******************************
logic clk = 1'h0, sys_rst = 1'h1;
logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
logic arvalid = 1'h0, rready = 1'h0, awready, wready, bvalid, arready;
logic rvalid, tx = 1'h0, am_en = 1'h1, pm_en = 1'h0, man = 1'h0;
logic single = 1'h0, am_on, pm_on, fr_pm, amd, lowp, lfs, lfe, agce, agcw;
logic agca, pmix, sq, clip, frc, cmax;
logic [1:0] bresp, rresp;
logic [2:0] lp, zr, g1a, g1p;
logic [3:0] g2a, g2p, wa, wp, ca, cp;
int miscompares = 0, tests_run = 0;
rxcf_regs rxcf_regs_i (.clk(clk), .sys_rst(sys_rst),
	.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
	.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
	.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
	.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
	.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
	.s_axi_rvalid(rvalid), .s_axi_rready(rready), .tx_active(tx),
	.rx_channel_am_en(am_en), .rx_channel_pm_en(pm_en),
	.rx_manual_select(man), .single_ended_mode(single),
	.rx_am_enable(am_on), .rx_pm_enable(pm_on), .framing_from_pm(fr_pm),
	.am_demod_mixer(amd), .lowpass_ctrl(lp), .zero_ctrl(zr),
	.receiver_low_power(lowp), .low_freq_input_split(lfs),
	.low_freq_input_enable(lfe), .agc_enable(agce), .agc_full_window(agcw),
	.agc_reset_alg(agca), .phase_mixer_clock_source(pmix),
	.squelch_active(sq), .am_first_stage_gain(g1a),
	.pm_first_stage_gain(g1p), .stage_clip(clip),
	.peer_mode_gain_force(frc), .am_later_stage_gain(g2a),
	.pm_later_stage_gain(g2p), .am_digitizer_widen(wa),
	.pm_digitizer_widen(wp), .am_stage23_cut(ca), .pm_stage23_cut(cp),
	.comparator_window_max(cmax));
// ******************************
// shared tasks
// ******************************
// free-running 20 MHz clock
initial forever #25 clk = ~clk;
task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
	tests_run++;
	if (seen !== exp) begin
		miscompares++;
		$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
	end
endtask
task automatic results;
	$display("compares %0d miscompares %0d", tests_run, miscompares);
	if (miscompares == 0 && tests_run > 0) begin
		$display("Result: passed");
	end else begin
		$display("Result: failed");
	end
	$finish;
endtask
task automatic tick(int k);
	repeat (k) @(posedge clk);
endtask
// write; ends two edges on so the controls have settled
task automatic wr(logic [31:0] a, logic [7:0] d, logic [1:0] r = 2'h0);
	int n;
	n = 0;
	awaddr <= a;
	wdata <= {24'h0, d};
	awvalid <= 1'h1;
	wvalid <= 1'h1;
	bready <= 1'h1;
	do begin
		@(posedge clk);
		if (awready) awvalid <= 1'h0;
		if (wready) wvalid <= 1'h0;
		n++;
	end while (!bvalid && n < 50);
	bready <= 1'h0;
	check("bresp", {bvalid, bresp}, {1'h1, r});
	tick(2);
endtask
task automatic rd(logic [31:0] a, logic [7:0] d, logic [1:0] r = 2'h0);
	int n;
	n = 0;
	araddr <= a;
	arvalid <= 1'h1;
	rready <= 1'h1;
	do begin
		@(posedge clk);
		if (arready) arvalid <= 1'h0;
		n++;
	end while (!rvalid && n < 50);
	rready <= 1'h0;
	check("read", {rvalid, rresp, rdata}, {1'h1, r, 24'h0, d});
	tick(1);
endtask
// ******************************
// scenarios
// ******************************
task automatic t_defaults;
	rd(32'h28, 8'h00);
	rd(32'h2C, 8'h1A);
	rd(32'h30, 8'hD8);
	rd(32'h34, 8'h00);
	rd(32'h38, 8'h08);
	check("dflt", {agce, agcw, agca, g1a, g1p, clip}, 10'h36C);
endtask
task automatic t_chan;
	for (int s = 0; s < 2; s++) begin
		wr(32'h28, {s[0], 7'h6B});
		check("filt", {amd, lp, zr}, 7'h6B);
		{am_en, pm_en, man} <= 3'h4;
		tick(3);
		check("one", {am_on, pm_on}, {~s[0], s[0]});
		{am_en, pm_en, man} <= 3'h7;
		tick(3);
		check("frame", fr_pm, s[0]);
		// both on without manual choice: select bit must not steer framing
		{am_en, pm_en, man} <= 3'h6;
		tick(3);
		check("auto", fr_pm, 1'h0);
		{am_en, pm_en, man} <= 3'h7;
	end
endtask
task automatic t_mode;
	wr(32'h2C, 8'hE5);
	check("mode", {lowp, lfs, lfe, agce, agcw, agca, pmix}, 7'h73);
	wr(32'h2C, 8'hE4);
	check("mixa", pmix, 1'h0);
	single <= 1'h1;
	tick(3);
	check("mixb", pmix, 1'h1);
	single <= 1'h0;
endtask
task automatic t_gain1;
	for (int c = 0; c < 8; c++) begin
		wr(32'h30, {c[2:0], ~c[2:0], 2'h2});
		check("g1", {g1a, g1p, clip, frc}, {c[2:0], ~c[2:0], 2'h2});
	end
	wr(32'h30, 8'h01);
	check("force", {frc, cmax, wa, ca, wp, cp}, 18'h34242);
	wr(32'h30, 8'hD8);
	// receiver restarted after the force bit is cleared
	{am_en, pm_en} <= 2'h0;
	tick(2);
	{am_en, pm_en} <= 2'h3;
	tick(3);
	check("unforce", {frc, cmax, wa, ca}, 10'h000);
endtask
task automatic t_gain2;
	logic [7:0] v [3] = '{8'hA3, 8'h54, 8'h01};
	logic [7:0] old;
	old = 8'h00;
	for (int i = 0; i < 3; i++) begin
		wr(32'h34, v[i]);
		check("held", {g2a, g2p}, old);
		rd(32'h34, v[i]);
		wr(32'h80, 8'h02);
		check("load", {g2a, g2p}, v[i]);
		check("am2", {wa, ca}, {mw(v[i][7:4]), mc(v[i][7:4])});
		check("pm2", {wp, cp}, {mw(v[i][3:0]), mc(v[i][3:0])});
		old = v[i];
	end
endtask
function automatic logic [3:0] mw(logic [3:0] c);
	return (c > 4'h4) ? 4'h4 : c;
endfunction
function automatic logic [3:0] mc(logic [3:0] c);
	return (c > 4'h4) ? c - 4'h4 : 4'h0;
endfunction
task automatic t_restore;
	wr(32'h28, 8'hFF);
	wr(32'h2C, 8'h00);
	wr(32'h30, 8'h00);
	wr(32'h34, 8'h77);
	wr(32'h80, 8'h01);
	t_defaults;
	check("copy", {g2a, g2p}, 8'h01);
	wr(32'h3C, 8'h55, 2'h2);
	rd(32'h3C, 8'h00, 2'h2);
endtask
// counts edges until squelch rises, then how long it stands
task automatic t_squelch(logic en);
	int n, m;
	n = 0;
	m = 0;
	tx <= 1'h1;
	tick(10);
	tx <= 1'h0;
	while (!sq && n < 1000) begin
		tick(1);
		n++;
	end
	while (sq && m < 1000) begin
		tick(1);
		m++;
	end
	check("sqst", en ? (n >= 370 && n <= 395) : n == 1000, 1'h1);
	check("sqlen", en ? (m >= 370 && m <= 392) : m == 0, 1'h1);
endtask
// transmit restarting inside the squelch window must end it at once
task automatic t_abort;
	int n;
	n = 0;
	tx <= 1'h1;
	tick(10);
	tx <= 1'h0;
	while (!sq && n < 1000) begin
		tick(1);
		n++;
	end
	tx <= 1'h1;
	tick(3);
	check("sqab", {n < 1000, sq}, 2'h2);
	tx <= 1'h0;
endtask
// ******************************
// main sequence and watchdog
// ******************************
initial begin
	repeat (16) @(posedge clk);
	sys_rst <= 1'h0;
	tick(1);
	t_defaults;
	t_chan;
	t_mode;
	t_gain1;
	t_gain2;
	t_restore;
	t_squelch(1'h1);
	t_abort;
	wr(32'h2C, 8'h18);
	t_squelch(1'h0);
	results;
end
// whole run needs well under 10000 edges; give up after 20000
initial begin
	#1000000;
	miscompares++;
	results;
end
endmodule
`default_nettype wire
